// >>> cal_regs_pkg.sv
// Constants for the calibration register bank
package cal_regs_pkg;
   // Register count and pointer width
   localparam int             CAL_REG_COUNT = 10;
   localparam int             PTR_W         = 4;
   // Pointer positions in the full sequence
   localparam logic [3:0]     PTR_GAIN      = 4'h0;
   localparam logic [3:0]     PTR_OFFSET    = 4'h1;
   localparam logic [3:0]     PTR_DAC_FIRST = 4'h2;
   localparam logic [3:0]     PTR_LAST      = 4'h9;
   // Data layout
   localparam int             DATA_W        = 14;
   localparam int             WORD_W        = 16;
   localparam int             BYTE_W        = 8;
   // Calibration select encodings
   localparam logic [1:0]     SEL_ALL       = 2'h0;
   localparam logic [1:0]     SEL_GAIN_OFS  = 2'h1;
   localparam logic [1:0]     SEL_OFS_ONLY  = 2'h2;
   localparam logic [1:0]     SEL_GAIN_ONLY = 2'h3;
   // Read target encodings
   localparam logic [1:0]     RD_CAL        = 2'h2;
   localparam logic [1:0]     RD_STATUS     = 2'h3;
   // Reset values of the data words
   localparam logic [13:0]    OFFSET_RESET  = 14'h2000;
   localparam logic [13:0]    GAIN_RESET    = 14'h2000;
   localparam logic [13:0]    DAC_RESET     = 14'h0000;
   // Status register fixed bits
   localparam logic [1:0]     STATUS_ONES   = 2'h3;
endpackage : cal_regs_pkg

// >>> adc_cal_register_access.sv
// Calibration register bank with auto-incrementing access pointer
// Operation
// - Ten calibration registers: eight DAC, offset and gain, all read and write.
// - Calibration engine updates registers itself during self and system calibration.
// - Select 00 sequence covers gain, offset and eight DAC registers.
// - Select 01 sequence covers gain then offset registers only.
// - Select 10 addresses offset only; select 11 addresses gain only.
// - Pointer resets on control write and after the last register of sequence.
// - Pointer resets to gain, or offset when offset-only is selected.
// - Pointer advances after each complete access in multi-register sequences.
// - Byte mode advances only after high byte; host sends low byte first.
// - Host may abandon a sequence; next control write resets pointer.
// - Calibration reads return two zero bits at the top.
// - Offset register is sixteen bits, top two zero, fourteen data bits.
// - Offset register default is near binary 0010 0000 0000 0000.
// - Offset bits binary weighted, top worth five percent of reference.
// - Larger offset value compensates positive offset, smaller negative.
// - Gain register sixteen bits, fourteen weighted bits, top worth 2.5 percent.
// - Gain value scales result, covering spans 0.975 to 1.025 of reference.
// - Conversion starts from control register command or start pin pulse.
// - Read target 11 routes reads to the read-only status register.
// - Status mirrors select bits and mode bit; running flag during calibration.
`timescale 1ns/10ps
`default_nettype none
module adc_cal_register_access
   import cal_regs_pkg::*;
#(
   parameter int N_REGS = cal_regs_pkg::CAL_REG_COUNT
)
(
   // Clock and reset
   input  wire logic                          REF_CLK,
   input  wire logic                          RST_N,
   // Control register write strobe and fields
   input  wire logic                          CTRL_WR,
   input  wire logic [1:0]                    CAL_SELECT,
   input  wire logic [1:0]                    READ_TARGET,
   input  wire logic                          SELF_OR_SYSTEM_CAL_SELECT,
   input  wire logic                          SOFT_START,
   // Host data bus access
   input  wire logic                          CAL_WR,
   input  wire logic                          CAL_RD,
   input  wire logic                          BYTE_MODE,
   input  wire logic                          UPPER_BYTE_ENABLE,
   input  wire logic [cal_regs_pkg::WORD_W-1:0] WR_DATA,
   output logic      [cal_regs_pkg::WORD_W-1:0] RD_DATA,
   // Start sources
   input  wire logic                          SAMPLE_START_PIN,
   output logic                               CONV_START,
   // Calibration engine update path
   input  wire logic                          CAL_RUNNING,
   input  wire logic                          ENG_WR,
   input  wire logic [cal_regs_pkg::PTR_W-1:0]  ENG_IDX,
   input  wire logic [cal_regs_pkg::DATA_W-1:0] ENG_DATA,
   // Correction values to the converter
   output logic      [cal_regs_pkg::DATA_W-1:0] OFFSET_CORRECTION,
   output logic      [cal_regs_pkg::DATA_W-1:0] GAIN_CORRECTION,
   output logic      [cal_regs_pkg::PTR_W-1:0]  CAL_POINTER
);

   // Pointer map of the full sequence:
   //   0      gain correction word
   //   1      offset correction word
   //   2..9   capacitor DAC trim words one to eight
   // Shorter sequences use a window of the same map. Two-register mode
   // runs 0 then 1, and each single-register mode parks on its own index.
   // The pointer only changes on a control write or on a completed word,
   // so an abandoned sequence simply sits until the next control write.
   //
   // Status word, low byte from bit 7 down:
   //   two ones, analog mode (not held here, reads 0), busy, mode bit,
   //   the two select bits, running flag.
   // Busy follows the calibration engine only. Conversion busy lives in
   // the converter and is not visible here, which is a known limitation.
   // The high byte carries channel and power fields kept elsewhere, so it
   // reads zero from this bank.

   // Whole state of the bank in one word
   typedef struct packed {
      logic [N_REGS-1:0][DATA_W-1:0] regs;
      logic [PTR_W-1:0]              ptr;
      logic [BYTE_W-1:0]             low_hold;
      logic [1:0]                    cal_select;
      logic [1:0]                    read_target;
      logic                          cal_mode;
      logic [WORD_W-1:0]             rd_data;
      logic                          conv_start;
   } state_s;

   state_s st;
   state_s next_st;

   // First register of a sequence
   function automatic logic [PTR_W-1:0] first_ptr(input logic [1:0] sel);
      first_ptr = (sel == SEL_OFS_ONLY) ? PTR_OFFSET : PTR_GAIN;
   endfunction : first_ptr

   // Last register of a sequence
   function automatic logic [PTR_W-1:0] last_ptr(input logic [1:0] sel);
      case (sel)
         SEL_ALL:      last_ptr = PTR_LAST;
         SEL_GAIN_OFS: last_ptr = PTR_OFFSET;
         SEL_OFS_ONLY: last_ptr = PTR_OFFSET;
         default:      last_ptr = PTR_GAIN;
      endcase
   endfunction : last_ptr

   logic             word_done;
   logic [WORD_W-1:0] wr_word;
   logic             cal_read;
   logic [DATA_W-1:0] wr_low;
   logic [DATA_W-1:0] pointed_word;

   // A full word ends on a word access or on the high byte in byte mode
   assign word_done = (CAL_WR | CAL_RD) & (~BYTE_MODE | UPPER_BYTE_ENABLE);
   assign cal_read  = CAL_RD & (st.read_target == RD_CAL);
   assign wr_word   = BYTE_MODE ? {WR_DATA[BYTE_W-1:0], st.low_hold} : WR_DATA;

   // Helpers for the checks; data bits of a committed word and of the pointed word
   assign wr_low       = wr_word[DATA_W-1:0];
   assign pointed_word = st.regs[st.ptr];

   // Next state
   always_comb
   begin
      next_st            = st;
      next_st.conv_start = CTRL_WR & SOFT_START | SAMPLE_START_PIN;
      // Engine writes during calibration; host write to same word wins later
      if (ENG_WR && CAL_RUNNING && ENG_IDX < PTR_W'(N_REGS))
      begin
         next_st.regs[ENG_IDX] = ENG_DATA;
      end
      if (CTRL_WR)
      begin
         next_st.cal_select  = CAL_SELECT;
         next_st.read_target = READ_TARGET;
         next_st.cal_mode    = SELF_OR_SYSTEM_CAL_SELECT;
         next_st.ptr         = first_ptr(CAL_SELECT);
      end
      else
      begin
         if (CAL_WR && BYTE_MODE && !UPPER_BYTE_ENABLE)
         begin
            next_st.low_hold = WR_DATA[BYTE_W-1:0];
         end
         if (CAL_WR && word_done)
         begin
            next_st.regs[st.ptr] = wr_word[DATA_W-1:0];
         end
         if (word_done && (CAL_WR || cal_read))
         begin
            if (st.ptr == last_ptr(st.cal_select))
            begin
               next_st.ptr = first_ptr(st.cal_select);
            end
            else
            begin
               next_st.ptr = st.ptr + PTR_W'(1);
            end
         end
      end
      // Read data registered; byte mode picks a lane
      if (st.read_target == RD_STATUS)
      begin
         next_st.rd_data = {8'h00, STATUS_ONES, 1'b0, CAL_RUNNING, st.cal_mode,
                            st.cal_select, CAL_RUNNING};
      end
      else
      begin
         next_st.rd_data = {2'h0, st.regs[st.ptr]};
      end
      if (BYTE_MODE)
      begin
         next_st.rd_data = UPPER_BYTE_ENABLE ? {8'h00, next_st.rd_data[WORD_W-1:BYTE_W]}
                                             : {8'h00, next_st.rd_data[BYTE_W-1:0]};
      end
   end

   // State register; offset default near mid-scale
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         st                     <= '0;
         st.regs                <= {N_REGS{DAC_RESET}};
         st.regs[PTR_OFFSET]    <= OFFSET_RESET;
         st.regs[PTR_GAIN]      <= GAIN_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs; corrections feed the converter datapath
   assign RD_DATA           = st.rd_data;
   assign CONV_START        = st.conv_start;
   assign OFFSET_CORRECTION = st.regs[PTR_OFFSET];
   assign GAIN_CORRECTION   = st.regs[PTR_GAIN];
   assign CAL_POINTER       = st.ptr;

   // Assertions
   ptr_reset_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      CTRL_WR |=> CAL_POINTER == first_ptr($past(CAL_SELECT)))
      else $error("pointer not reset by control write");
   ptr_range_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      CAL_POINTER <= PTR_LAST)
      else $error("pointer out of range");
   low_byte_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (BYTE_MODE && !UPPER_BYTE_ENABLE && !CTRL_WR) |=> $stable(CAL_POINTER))
      else $error("pointer moved on low byte");
   lead_zeros_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      RD_DATA[WORD_W-1:WORD_W-2] == 2'h0)
      else $error("leading bits not zero");
   single_reg_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (st.cal_select == SEL_GAIN_ONLY && !CTRL_WR) |=> CAL_POINTER == PTR_GAIN)
      else $error("gain-only pointer moved");
   ofs_only_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (st.cal_select == SEL_OFS_ONLY && !CTRL_WR) |=> CAL_POINTER == PTR_OFFSET)
      else $error("offset-only pointer moved");
   wrap_two_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (st.cal_select == SEL_GAIN_OFS && !CTRL_WR) |=> CAL_POINTER <= PTR_OFFSET)
      else $error("two-register sequence overran");
   start_pin_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      SAMPLE_START_PIN |=> CONV_START)
      else $error("start pin ignored");
   status_mirror_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (st.read_target == RD_STATUS && !BYTE_MODE) |=>
      RD_DATA[2:1] == $past(st.cal_select))
      else $error("status does not mirror select");

   // Steps of a data access. A completed word either moves the pointer on
   // or closes the sequence; the two cases are kept apart so that a stuck
   // or a runaway pointer shows up in a different check.
   sequence full_access_s;
      !CTRL_WR && word_done && (CAL_WR || cal_read) &&
      st.ptr != last_ptr(st.cal_select);
   endsequence

   sequence last_access_s;
      !CTRL_WR && word_done && (CAL_WR || cal_read) &&
      st.ptr == last_ptr(st.cal_select);
   endsequence

   sequence gain_commit_s;
      !CTRL_WR && CAL_WR && word_done && st.ptr == PTR_GAIN;
   endsequence

   sequence offset_commit_s;
      !CTRL_WR && CAL_WR && word_done && st.ptr == PTR_OFFSET;
   endsequence

   // Pointer steps by one inside a sequence
   ptr_advance_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      full_access_s |=> CAL_POINTER == $past(CAL_POINTER) + 4'h1)
      else $error("pointer did not advance");

   // Pointer returns to the head after the last word
   ptr_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      last_access_s |=> CAL_POINTER == first_ptr(st.cal_select))
      else $error("pointer did not wrap");

   // Without a control write or a whole word the pointer stays put
   ptr_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (!CTRL_WR && !word_done) |=> $stable(CAL_POINTER))
      else $error("pointer moved while idle");

   // Status reads must not consume calibration words
   status_no_step_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CAL_RD && !CAL_WR && !CTRL_WR && st.read_target == RD_STATUS) |=>
      $stable(CAL_POINTER))
      else $error("status read moved pointer");

   // Offset word is followed by the first DAC word in the full sequence
   dac_order_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (full_access_s and (st.cal_select == SEL_ALL && st.ptr == PTR_OFFSET)) |=>
      CAL_POINTER == PTR_DAC_FIRST)
      else $error("DAC words out of order");

   // A host word lands in the gain register, engine traffic aside
   gain_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      gain_commit_s |=> GAIN_CORRECTION == $past(wr_low))
      else $error("gain write lost");

   // A host word lands in the offset register
   offset_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      offset_commit_s |=> OFFSET_CORRECTION == $past(wr_low))
      else $error("offset write lost");

   // Engine writes outside calibration leave the corrections alone
   eng_refused_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (ENG_WR && !CAL_RUNNING && !CAL_WR) |=>
      $stable(OFFSET_CORRECTION) && $stable(GAIN_CORRECTION))
      else $error("engine write taken while idle");

   // Engine writes to the offset word during calibration update it
   eng_taken_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (ENG_WR && CAL_RUNNING && !CAL_WR && ENG_IDX == PTR_OFFSET) |=>
      OFFSET_CORRECTION == $past(ENG_DATA))
      else $error("engine write dropped");

   // Word reads return the pointed register under two zero bits
   cal_read_data_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (st.read_target == RD_CAL && !BYTE_MODE) |=>
      RD_DATA[DATA_W-1:0] == $past(pointed_word))
      else $error("read data not the pointed word");

   // Byte mode only drives the low lane
   byte_lane_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      BYTE_MODE |=> RD_DATA[WORD_W-1:BYTE_W] == 8'h00)
      else $error("byte read drove high lane");

   // Software start from the control write
   soft_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CTRL_WR && SOFT_START) |=> CONV_START)
      else $error("software start ignored");

   // No start without a request
   no_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (!CTRL_WR && !SAMPLE_START_PIN) |=> !CONV_START)
      else $error("spurious conversion start");

   // Running flag and busy follow the engine, mode bit follows control
   status_flags_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (st.read_target == RD_STATUS && !BYTE_MODE) |=>
      (RD_DATA[0] == $past(CAL_RUNNING) && RD_DATA[4] == $past(CAL_RUNNING) &&
       RD_DATA[3] == $past(st.cal_mode)))
      else $error("status flags wrong");

   // Fixed ones of the status word
   status_ones_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (st.read_target == RD_STATUS && !BYTE_MODE) |=> RD_DATA[7:6] == STATUS_ONES)
      else $error("status fixed bits wrong");

   // Offset-only selection parks on the offset word after a control write
   ofs_head_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CTRL_WR && CAL_SELECT == SEL_OFS_ONLY) |=> CAL_POINTER == PTR_OFFSET)
      else $error("offset-only head wrong");

   // Every other selection starts at the gain word
   gain_head_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CTRL_WR && CAL_SELECT != SEL_OFS_ONLY) |=> CAL_POINTER == PTR_GAIN)
      else $error("sequence head wrong");

   // A control write in mid-sequence pulls the pointer back
   abort_reset_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CTRL_WR && CAL_POINTER > PTR_OFFSET) |=> CAL_POINTER <= PTR_OFFSET)
      else $error("abort left pointer in place");

endmodule : adc_cal_register_access
`default_nettype wire

// >>> cal_host_model.sv
// Host processor model driving the control and calibration data bus
`timescale 1ns/10ps
`default_nettype none
module cal_host_model
(
   // Clock
   input  wire logic        clk,
   // Control write fields
   output logic             ctrl_wr,
   output logic [1:0]       cal_select,
   output logic [1:0]       read_target,
   output logic             cal_mode,
   output logic             soft_start,
   // Calibration data bus
   output logic             cal_wr,
   output logic             cal_rd,
   output logic             byte_mode,
   output logic             upper_byte_enable,
   output logic [15:0]      wr_data,
   input  wire logic [15:0] rd_data
);
   initial {ctrl_wr, cal_select, read_target, cal_mode, soft_start} = '0;
   initial {cal_wr, cal_rd, byte_mode, upper_byte_enable, wr_data} = '0;
   // Select and read target always travel in the same control write
   task automatic ctrl(input logic [1:0] sel, input logic [1:0] tgt, input logic md, input logic st);
      @(negedge clk);
      {ctrl_wr, cal_select, read_target, cal_mode, soft_start} = {1'b1, sel, tgt, md, st};
      @(negedge clk);
      {ctrl_wr, soft_start} = 2'h0;
   endtask : ctrl
   // One access; lane is held until the answer is sampled
   task automatic access(input logic wr, input logic ube, input logic [15:0] d,
                         output logic [15:0] q);
      @(negedge clk);
      {cal_wr, cal_rd, upper_byte_enable, wr_data} = {wr, ~wr, ube, d};
      @(negedge clk);
      {cal_wr, cal_rd} = 2'h0;
      wr_data = ~d; // Released bus must not keep the old value
      q = rd_data;
   endtask : access
endmodule : cal_host_model
`default_nettype wire

// >>> adc_cal_register_access_test.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/10ps
`default_nettype none
module adc_cal_register_access_test;
   import cal_regs_pkg::*;
   typedef struct {logic [1:0] sel; logic [3:0] first; int n;} row_s;
   logic REF_CLK = 0, RST_N = 0, CTRL_WR, CAL_WR, CAL_RD, BYTE_MODE, UBE, MODE, SOFT;
   logic PIN = 0, RUN = 0, ENG_WR = 0, CONV_START;
   logic [1:0] SEL, TGT;
   logic [3:0] ENG_IDX = 0, PTR;
   logic [13:0] ENG_DATA = 0, OFS, GAIN;
   logic [15:0] WR_DATA, RD_DATA, q;
   int failures = 0, cmp_count = 0;
   row_s rows[4] = '{'{SEL_ALL, PTR_GAIN, 10}, '{SEL_GAIN_OFS, PTR_GAIN, 2},
                     '{SEL_OFS_ONLY, PTR_OFFSET, 1}, '{SEL_GAIN_ONLY, PTR_GAIN, 1}};
   always #10 REF_CLK = ~REF_CLK;
   adc_cal_register_access u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CTRL_WR(CTRL_WR),
      .CAL_SELECT(SEL), .READ_TARGET(TGT), .SELF_OR_SYSTEM_CAL_SELECT(MODE), .SOFT_START(SOFT),
      .CAL_WR(CAL_WR), .CAL_RD(CAL_RD), .BYTE_MODE(BYTE_MODE), .UPPER_BYTE_ENABLE(UBE),
      .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .SAMPLE_START_PIN(PIN), .CONV_START(CONV_START),
      .CAL_RUNNING(RUN), .ENG_WR(ENG_WR), .ENG_IDX(ENG_IDX), .ENG_DATA(ENG_DATA),
      .OFFSET_CORRECTION(OFS), .GAIN_CORRECTION(GAIN), .CAL_POINTER(PTR));
   cal_host_model u_host (.clk(REF_CLK), .ctrl_wr(CTRL_WR), .cal_select(SEL),
      .read_target(TGT), .cal_mode(MODE), .soft_start(SOFT), .cal_wr(CAL_WR), .cal_rd(CAL_RD),
      .byte_mode(BYTE_MODE), .upper_byte_enable(UBE), .wr_data(WR_DATA), .rd_data(RD_DATA));
   // Single comparison point
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // Reset for n cycles, then look at the documented defaults
   task automatic reset_check(input int n);
      @(negedge REF_CLK) RST_N = 0;
      repeat (n) @(negedge REF_CLK);
      check("read data in reset", RD_DATA, 16'h0000);
      RST_N = 1;
      @(negedge REF_CLK);
      check("pointer", 16'(PTR), 16'(PTR_GAIN));
      check("offset", 16'(OFS), 16'h2000);
      check("gain", 16'(GAIN), 16'(GAIN_RESET));
      check("read data", RD_DATA, {2'h0, GAIN_RESET});
   endtask : reset_check
   // Watchdog; the whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge REF_CLK);
      failures++;
      report_and_stop();
   end
   initial
   begin
      reset_check(12);
      // Every select code: write a whole sequence, then read it back
      foreach (rows[r])
      begin
         u_host.ctrl(rows[r].sel, RD_CAL, 1'b0, 1'b0);
         check("first pointer", 16'(PTR), 16'(rows[r].first));
         for (int i = 0; i < rows[r].n; i++)
            u_host.access(1'b1, 1'b0, 16'hc000 | 16'(16'h0111 * (i + r + 1)), q);
         check("wrapped pointer", 16'(PTR), 16'(rows[r].first));
         for (int i = 0; i < rows[r].n; i++)
         begin
            u_host.access(1'b0, 1'b0, 16'h0000, q);
            check("read back", q, 16'h3fff & 16'(16'h0111 * (i + r + 1)));
         end
         if (r == 0)
            check("order", {OFS[7:0], GAIN[7:0]}, 16'h2211);
      end
      // Byte mode: pointer moves only on the high byte
      u_host.ctrl(SEL_GAIN_OFS, RD_CAL, 1'b0, 1'b0);
      u_host.byte_mode = 1'b1;
      u_host.access(1'b1, 1'b0, 16'h0034, q);
      check("low byte pointer", 16'(PTR), 16'h0000);
      u_host.access(1'b1, 1'b1, 16'h0012, q);
      check("high byte pointer", 16'(PTR), 16'h0001);
      check("byte gain", 16'(GAIN), 16'h1234);
      u_host.ctrl(SEL_GAIN_OFS, RD_CAL, 1'b0, 1'b0);
      u_host.access(1'b0, 1'b0, 16'h0000, q);
      check("low byte read", 16'(q[7:0]), 16'h0034);
      u_host.access(1'b0, 1'b1, 16'h0000, q);
      check("high byte read", 16'(q[7:0]), 16'h0012);
      u_host.byte_mode = 1'b0;
      // Abandoned sequence is reset by the next control write
      u_host.ctrl(SEL_ALL, RD_CAL, 1'b0, 1'b0);
      repeat (3) u_host.access(1'b0, 1'b0, 16'h0000, q);
      check("mid pointer", 16'(PTR), 16'h0003);
      u_host.ctrl(SEL_ALL, RD_CAL, 1'b0, 1'b0);
      check("abort pointer", 16'(PTR), 16'h0000);
      // Status read, then engine writes refused and taken
      u_host.ctrl(SEL_OFS_ONLY, RD_STATUS, 1'b1, 1'b0);
      repeat (2) @(negedge REF_CLK);
      check("status idle", RD_DATA, 16'h00cc);
      for (int k = 0; k < 2; k++)
      begin
         RUN = k[0];
         @(negedge REF_CLK) {ENG_WR, ENG_IDX, ENG_DATA} = {1'b1, PTR_OFFSET, 14'h0abc};
         @(negedge REF_CLK) ENG_WR = 1'b0;
         check("engine offset", 16'(OFS), k ? 16'h0abc : 16'h0333);
      end
      @(negedge REF_CLK);
      check("status running", RD_DATA, 16'h00dd);
      RUN = 1'b0;
      // Start from the pin and from the control write
      for (int k = 0; k < 2; k++)
      begin
         if (k)
            u_host.ctrl(SEL_ALL, RD_CAL, 1'b0, 1'b1);
         else
         begin
            @(negedge REF_CLK) PIN = 1'b1;
            @(negedge REF_CLK) PIN = 1'b0;
         end
         check("start pulse", 16'(CONV_START), 16'h0001);
         @(negedge REF_CLK) check("start ends", 16'(CONV_START), 16'h0000);
      end
      reset_check(2);
      report_and_stop();
   end
endmodule : adc_cal_register_access_test
`default_nettype wire
